// >>> inc/cgc_pkg.sv
// Purpose: Shared constants, types and decode helpers of the clock
//          generator configuration block.
// Assumes: A 125 MHz core clock and a 32-bit APB register port.
// Notes:   Every offset, field position, reset value and count lives here.
`default_nettype none

package cgc_pkg;

  // Register byte offsets, one aligned 32-bit word each.
  localparam logic [11:0] ADDR_CTRL1 = 12'h000;
  localparam logic [11:0] ADDR_CTRL2 = 12'h004;
  localparam logic [11:0] ADDR_STAT1 = 12'h008;
  localparam logic [11:0] ADDR_STAT2 = 12'h00c;
  localparam logic [11:0] ADDR_FLTU = 12'h010;
  localparam logic [11:0] ADDR_FLTL = 12'h014;
  localparam logic [11:0] ADDR_TRIM = 12'h018;

  // Field positions in clock_gen_control_1.
  localparam int C1_HGO = 7;
  localparam int C1_RANGE = 6;
  localparam int C1_REFERENCE_SELECT = 5;
  localparam int C1_CLOCK_MODE_REQUEST_LSB = 3;

  // Field positions in clock_gen_control_2.
  localparam int C2_MFD_LSB = 4;
  localparam int C2_RFD_LSB = 0;

  // Field positions in clock_gen_status_1.
  localparam int S1_CLOCK_MODE_ACTUAL_LSB = 6;
  localparam int S1_REFST = 5;
  localparam int S1_LOCK = 3;
  localparam int S1_ERCS = 1;

  // Writable bit masks; bit 0 of control 1 is reserved.
  localparam logic [7:0] CTRL1_MASK = 8'hfe;
  localparam logic [3:0] FLTU_MASK = 4'hf;

  // Values after reset: self-clocked mode, nothing requested.
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [11:0] FILTER_RST = 12'h000;
  localparam logic [7:0] TRIM_RST = 8'h80;

  // Frequency-equation constants.
  localparam logic [6:0] PRESCALE_LOW = 7'h40;
  localparam logic [6:0] PRESCALE_HIGH = 7'h01;
  localparam logic [4:0] MULT_BASE = 5'h04;

  // Timing: core clock period and derived cycle counts (least times).
  localparam int CLK_PERIOD_NS = 8;
  localparam int OSC_STARTUP_NS = 1000;
  localparam int DCO_SETTLE_NS = 200;
  localparam logic [7:0] OSC_STARTUP_CYCLES =
    8'((OSC_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] DCO_SETTLE_CYCLES =
    8'((DCO_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] MODE_SETTLE_CYCLES = 4'h4;

  // Clock modes in the order of their two-bit codes.
  typedef enum logic [1:0] {
    MODE_SELF_CLOCKED,
    MODE_LOOP_INTERNAL,
    MODE_BYPASS_EXTERNAL,
    MODE_LOOP_EXTERNAL
  } cgc_mode_t;

  // Multiply code to N: four upward in steps of two.
  function automatic logic [4:0] cgc_mult_n(input logic [2:0] code);
    cgc_mult_n = MULT_BASE + {1'b0, code, 1'b0};
  endfunction : cgc_mult_n

  // Divide code to R: a power of two from one to 128.
  function automatic logic [7:0] cgc_div_r(input logic [2:0] code);
    cgc_div_r = 8'h01 << code;
  endfunction : cgc_div_r

endpackage : cgc_pkg

`default_nettype wire

// >>> verilog/cgc_settle_timer.sv
// Purpose: Counts a fixed settling delay while its enable stays high.
// Assumes: Enable and restart come from logic on the same clock.
// Notes:   Done falls on the next clock edge when the enable drops or a restart arrives.
`default_nettype none

module cgc_settle_timer #(
  parameter logic [7:0] LIMIT = 8'h01
) (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Control.
  input wire logic i_enable,
  input wire logic i_restart,
  // Status.
  output logic o_done
);
  import cgc_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic done;
  } cgc_timer_t;

  cgc_timer_t st;
  cgc_timer_t next_st;

  // A restart wins over counting so a new setting always waits in full.
  always_comb begin
    next_st = st;
    if (!i_enable || i_restart) begin
      next_st.cnt = 8'h00;
      next_st.done = 1'b0;
    end else if (!st.done) begin
      if (st.cnt == LIMIT - 8'h01) begin
        next_st.done = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 8'h01;
      end
    end
  end

  // State register.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_done = st.done;

endmodule : cgc_settle_timer

`default_nettype wire

// >>> verilog/cgc_clock_gen_config.sv
// Purpose: Mode control and frequency selection of the clock generator,
//          programmed through an APB register port.
// Assumes: Outside oscillators and dividers follow these outputs.
// Notes:   Every output is registered; the rules it keeps follow.
// Contract
// - High gain bit selects high-gain oscillator.
// - Gain applies in both ranges, only with oscillator.
// - New gain waits full oscillator start-up delay.
// - Self-clocked output is oscillator clock over R.
// - Bypassed external output is external over R.
// - Internal loop: reference/7 times 64 N/R.
// - External loop: external times P N over R.
// - Decode N four to eighteen, R powers two.
// - Bypassed external keeps both internal oscillators off.
// - Self-clocked: reference off, oscillator open loop.
// - Internal loop runs both internal oscillators.
// - Actual mode follows request after several cycles.
`default_nettype none

module cgc_clock_gen_config (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_srst,
  // APB slave port.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // External oscillator control.
  output logic o_ext_osc_enable,
  output logic o_ext_osc_high_gain,
  output logic o_ext_osc_range,
  // Internal oscillator control.
  output logic o_irg_enable,
  output logic o_dco_enable,
  output logic o_dco_loop_closed,
  output logic [11:0] o_dco_filter,
  output logic [7:0] o_osc_trim,
  // Output clock path selection and factors.
  output logic [1:0] o_mode_actual,
  output logic o_out_external,
  output logic o_ref_div7,
  output logic [6:0] o_prescale,
  output logic [4:0] o_mult_n,
  output logic [7:0] o_div_r
);
  import cgc_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [11:0] filter;
    logic [7:0] trim;
    cgc_mode_t actual;
    logic [3:0] settle;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic osc_en;
    logic osc_hg;
    logic osc_range;
    logic irg_en;
    logic dco_en;
    logic loop_closed;
    logic out_ext;
    logic ref_div7;
    logic [6:0] prescale;
    logic [4:0] mult_n;
    logic [7:0] div_r;
  } cgc_state_t;

  cgc_state_t st;
  cgc_state_t next_st;

  // Timer outputs and request fields.
  logic ercs;
  logic dcos;
  logic osc_restart;
  logic req_hgo;
  logic req_range;
  logic req_reference_select;
  cgc_mode_t req_mode;
  logic [2:0] mfd_code;
  logic [2:0] rfd_code;

  // Fields of the control registers as software last wrote them.
  assign req_hgo = st.ctrl1[C1_HGO];
  assign req_range = st.ctrl1[C1_RANGE];
  assign req_reference_select = st.ctrl1[C1_REFERENCE_SELECT];
  assign req_mode = cgc_mode_t'(st.ctrl1[C1_CLOCK_MODE_REQUEST_LSB +: 2]);
  assign mfd_code = st.ctrl2[C2_MFD_LSB +: 3];
  assign rfd_code = st.ctrl2[C2_RFD_LSB +: 3];

  // A gain change seen while the oscillator runs restarts its start-up.
  // Software is expected to stop the oscillator first; this only keeps
  // a careless write from switching to an unsettled crystal.
  assign osc_restart = st.osc_en && (st.osc_hg != req_hgo);

  // External oscillator start-up; done is the reference-present flag.
  cgc_settle_timer #(
    .LIMIT(OSC_STARTUP_CYCLES)
  ) u_osc_timer (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_enable(st.osc_en),
    .i_restart(osc_restart),
    .o_done(ercs)
  );

  // Internal oscillator settling; done is the oscillator-stable flag.
  cgc_settle_timer #(
    .LIMIT(DCO_SETTLE_CYCLES)
  ) u_dco_timer (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_enable(st.dco_en),
    .i_restart(1'b0),
    .o_done(dcos)
  );

  // Register index decode, shared by the read and the write path.
  function automatic logic [2:0] reg_index(input logic [11:0] addr);
    if (addr == ADDR_CTRL1) begin
      reg_index = 3'h1;
    end else if (addr == ADDR_CTRL2) begin
      reg_index = 3'h2;
    end else if (addr == ADDR_STAT1) begin
      reg_index = 3'h3;
    end else if (addr == ADDR_STAT2) begin
      reg_index = 3'h4;
    end else if (addr == ADDR_FLTU) begin
      reg_index = 3'h5;
    end else if (addr == ADDR_FLTL) begin
      reg_index = 3'h6;
    end else if (addr == ADDR_TRIM) begin
      reg_index = 3'h7;
    end else begin
      reg_index = 3'h0;
    end
  endfunction : reg_index

  // Whether the requested mode may be entered from the present one.
  // Each external mode needs a started oscillator, each loop mode a
  // settled internal oscillator.
  function automatic logic mode_ready(input cgc_mode_t target,
                                      input cgc_mode_t now,
                                      input logic ext_ok,
                                      input logic dco_ok);
    mode_ready = 1'b0;
    case (target)
      MODE_SELF_CLOCKED: begin
        mode_ready = (now != MODE_BYPASS_EXTERNAL) || dco_ok;
      end
      MODE_LOOP_INTERNAL: begin
        mode_ready = dco_ok;
      end
      MODE_BYPASS_EXTERNAL: begin
        mode_ready = ext_ok;
      end
      MODE_LOOP_EXTERNAL: begin
        mode_ready = ext_ok && dco_ok;
      end
      default: begin
        mode_ready = 1'b0;
      end
    endcase
  endfunction : mode_ready

  // Next state: bus slave, mode sequencing and output selection.
  always_comb begin
    logic [2:0] idx;
    logic access;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    idx = reg_index(i_paddr);
    access = i_psel && i_penable && !st.pready;
    wbyte = i_pwdata[7:0];
    rbyte = 8'h00;
    next_st = st;

    // Bus: ready comes one cycle into the access phase, then drops.
    next_st.pready = access;
    next_st.pslverr = access && (idx == 3'h0);
    if (!access) begin
      next_st.prdata = 32'h0000_0000;
    end

    // Read data; unimplemented and upper bits read as zero.
    case (idx)
      3'h1: begin
        rbyte = st.ctrl1 & CTRL1_MASK;
      end
      3'h2: begin
        rbyte = st.ctrl2;
      end
      3'h3: begin
        rbyte = 8'h00;
        rbyte[S1_CLOCK_MODE_ACTUAL_LSB +: 2] = st.actual;
        rbyte[S1_REFST] = req_reference_select;
        rbyte[S1_LOCK] = st.loop_closed && dcos;
        rbyte[S1_ERCS] = ercs;
      end
      3'h4: begin
        rbyte = {7'h00, dcos};
      end
      3'h5: begin
        rbyte = {4'h0, st.filter[11:8]};
      end
      3'h6: begin
        rbyte = st.filter[7:0];
      end
      3'h7: begin
        rbyte = st.trim;
      end
      default: begin
        rbyte = 8'h00;
      end
    endcase
    if (access && !i_pwrite) begin
      next_st.prdata = {24'h000000, rbyte};
    end

    // Writes take effect in the cycle ready is seen; status is read-only.
    if (i_psel && i_penable && st.pready && i_pwrite) begin
      case (idx)
        3'h1: begin
          next_st.ctrl1 = wbyte & CTRL1_MASK;
        end
        3'h2: begin
          next_st.ctrl2 = wbyte;
        end
        3'h5: begin
          next_st.filter[11:8] = wbyte[3:0] & FLTU_MASK;
        end
        3'h6: begin
          next_st.filter[7:0] = wbyte;
        end
        3'h7: begin
          next_st.trim = wbyte;
        end
        default: begin
          next_st.trim = st.trim;
        end
      endcase
    end

    // Mode sequencing: the actual mode follows the request only after
    // its conditions hold for a few cycles, so status lags the write.
    if ((req_mode == st.actual) ||
        !mode_ready(req_mode, st.actual, ercs, dcos)) begin
      next_st.settle = 4'h0;
    end else if (st.settle == MODE_SETTLE_CYCLES - 4'h1) begin
      next_st.actual = req_mode;
      next_st.settle = 4'h0;
    end else begin
      next_st.settle = st.settle + 4'h1;
    end

    // Oscillator runs for any external request with an oscillator chosen.
    next_st.osc_en = req_reference_select &&
      ((req_mode == MODE_BYPASS_EXTERNAL) ||
       (req_mode == MODE_LOOP_EXTERNAL));
    next_st.osc_hg = req_hgo && req_reference_select;
    next_st.osc_range = req_range;

    // Internal reference only for the internal loop.
    next_st.irg_en = (st.actual == MODE_LOOP_INTERNAL) ||
      (req_mode == MODE_LOOP_INTERNAL);
    // Oscillator off only while bypass is both held and requested.
    next_st.dco_en = !((st.actual == MODE_BYPASS_EXTERNAL) &&
      (req_mode == MODE_BYPASS_EXTERNAL));
    // Loop correction only in the two engaged modes.
    next_st.loop_closed = (st.actual == MODE_LOOP_INTERNAL) ||
      (st.actual == MODE_LOOP_EXTERNAL);

    // Output path and factors for the mode in effect.
    next_st.mult_n = cgc_mult_n(mfd_code);
    next_st.div_r = cgc_div_r(rfd_code);
    case (st.actual)
      MODE_SELF_CLOCKED: begin
        next_st.out_ext = 1'b0;
        next_st.ref_div7 = 1'b0;
        next_st.prescale = PRESCALE_HIGH;
      end
      MODE_LOOP_INTERNAL: begin
        next_st.out_ext = 1'b0;
        next_st.ref_div7 = 1'b1;
        next_st.prescale = PRESCALE_LOW;
      end
      MODE_BYPASS_EXTERNAL: begin
        next_st.out_ext = 1'b1;
        next_st.ref_div7 = 1'b0;
        next_st.prescale = PRESCALE_HIGH;
      end
      default: begin
        next_st.out_ext = 1'b0;
        next_st.ref_div7 = 1'b0;
        next_st.prescale = req_range ? PRESCALE_HIGH : PRESCALE_LOW;
      end
    endcase
  end

  // State register; after reset the generator is self-clocked.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st <= '0;
      st.ctrl1 <= CTRL1_RST;
      st.ctrl2 <= CTRL2_RST;
      st.filter <= FILTER_RST;
      st.trim <= TRIM_RST;
      st.actual <= MODE_SELF_CLOCKED;
      st.dco_en <= 1'b1;
      st.prescale <= PRESCALE_HIGH;
      st.mult_n <= MULT_BASE;
      st.div_r <= 8'h01;
    end else begin
      st <= next_st;
    end
  end

  // Every output comes straight from the state register.
  assign o_prdata = st.prdata;
  assign o_pready = st.pready;
  assign o_pslverr = st.pslverr;
  assign o_ext_osc_enable = st.osc_en;
  assign o_ext_osc_high_gain = st.osc_hg;
  assign o_ext_osc_range = st.osc_range;
  assign o_irg_enable = st.irg_en;
  assign o_dco_enable = st.dco_en;
  assign o_dco_loop_closed = st.loop_closed;
  assign o_dco_filter = st.filter;
  assign o_osc_trim = st.trim;
  assign o_mode_actual = st.actual;
  assign o_out_external = st.out_ext;
  assign o_ref_div7 = st.ref_div7;
  assign o_prescale = st.prescale;
  assign o_mult_n = st.mult_n;
  assign o_div_r = st.div_r;

endmodule : cgc_clock_gen_config

`default_nettype wire

// >>> dv/cgc_clock_gen_config_sva.sv
// Purpose: Port checks of the clock generator configuration.
// Assumes: One clock domain; bound to the top module.
// Notes:   Derived outputs lag the mode output by one cycle.
`default_nettype none

module cgc_clock_gen_config_sva
  import cgc_pkg::*;
(
  // Clock, reset and APB.
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Generator control.
  input wire logic o_ext_osc_enable,
  input wire logic o_ext_osc_range,
  input wire logic o_dco_loop_closed,
  input wire logic [1:0] o_mode_actual,
  input wire logic o_out_external,
  input wire logic o_ref_div7,
  input wire logic [6:0] o_prescale,
  input wire logic [4:0] o_mult_n,
  input wire logic [7:0] o_div_r
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);

  // An access phase still waiting for its answer.
  sequence s_waiting;
    i_psel && i_penable && !o_pready;
  endsequence
  // Oscillator starting while the output is still internal.
  sequence s_osc_start;
    $rose(o_ext_osc_enable) && !o_mode_actual[1];
  endsequence

  // The answer comes after one wait state and stands one cycle.
  a_ready_wait: assert property (s_waiting |=> o_pready)
    else $error("pready late");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready held");
  a_err_ready: assert property (o_pslverr |-> o_pready)
    else $error("pslverr alone");
  a_rdata_zero: assert property (o_prdata[31:8] == 24'h0 &&
    (o_pready || o_prdata == 32'h0)) else $error("read data leak");
  // Decoded factors stay on the legal grid.
  a_mult_grid: assert property (o_mult_n >= MULT_BASE &&
    o_mult_n <= 5'h12 && !o_mult_n[0]) else $error("bad N");
  a_div_power: assert property ($onehot(o_div_r))
    else $error("bad R");
  // Path selection is registered from the mode, so it trails by one.
  a_loop_closed: assert property
    (o_dco_loop_closed == $past(o_mode_actual[0])) else $error("loop");
  a_bypass_out: assert property
    (o_out_external == ($past(o_mode_actual) == 2'b10)) else $error("ext");
  a_ref_div7: assert property
    (o_ref_div7 == ($past(o_mode_actual) == 2'b01)) else $error("div7");
  a_prescale: assert property
    ($past(o_mode_actual) == 2'b11 && $stable(o_ext_osc_range) |->
     o_prescale == (o_ext_osc_range ? PRESCALE_HIGH : PRESCALE_LOW))
    else $error("prescale");
  // No switch to the oscillator within 120 cycles of its start.
  a_osc_startup: assert property
    (s_osc_start |-> !o_mode_actual[1] throughout (##120 1'b1))
    else $error("switched early");
endmodule : cgc_clock_gen_config_sva

bind cgc_clock_gen_config cgc_clock_gen_config_sva u_sva (
  .i_core_clk(i_core_clk), .i_srst(i_srst), .i_psel(i_psel),
  .i_penable(i_penable), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_ext_osc_enable(o_ext_osc_enable),
  .o_ext_osc_range(o_ext_osc_range),
  .o_dco_loop_closed(o_dco_loop_closed), .o_mode_actual(o_mode_actual),
  .o_out_external(o_out_external), .o_ref_div7(o_ref_div7),
  .o_prescale(o_prescale), .o_mult_n(o_mult_n), .o_div_r(o_div_r)
);

`default_nettype wire

// >>> dv/cgc_ext_osc_model.sv
// Purpose: External crystal on the generator's oscillator pins.
// Assumes: Enable, gain and range come from the block under test.
// Notes:   Gain only changes amplitude, which logic cannot show.
`default_nettype none

module cgc_ext_osc_model
  import cgc_pkg::*;
(
  // Amplifier control.
  input wire logic i_enable,
  input wire logic i_high_gain,
  input wire logic i_range,
  // Reference clock.
  output logic o_ref_clk
);
  timeunit 1ns;
  timeprecision 1ps;

  int unsigned age_ns;

  // The crystal stands low while disabled and starts over on every
  // enable, so a cut-short run never leaks a late edge afterwards.
  initial begin
    o_ref_clk = 1'b0;
    age_ns = 0;
    forever begin
      #1;
      if (i_enable !== 1'b1) begin
        age_ns = 0;
        o_ref_clk = 1'b0;
      end else begin
        age_ns++;
        if (age_ns > OSC_STARTUP_NS &&
            (age_ns - OSC_STARTUP_NS) % (i_range ? 125 : 2000) == 0) begin
          o_ref_clk = ~o_ref_clk;
        end
      end
    end
  end
endmodule : cgc_ext_osc_model

`default_nettype wire

// >>> dv/cgc_clock_gen_config_test.sv
// Purpose: Self-checking bench of the clock generator configuration.
// Assumes: 125 MHz core clock; APB driven on rising edges.
// Notes:   Mode waits are bounded; oscillator start-up is 125 cycles.
`default_nettype none

module cgc_clock_gen_config_test import cgc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  logic [31:0] o_prdata, rd, v, b;
  logic [11:0] o_dco_filter;
  logic [7:0] o_osc_trim, o_div_r;
  logic [6:0] o_prescale;
  logic [4:0] o_mult_n;
  logic [1:0] o_mode_actual;
  logic o_pready, o_pslverr, o_ext_osc_enable, o_ext_osc_high_gain;
  logic o_ext_osc_range, o_irg_enable, o_dco_enable, o_dco_loop_closed;
  logic o_out_external, o_ref_div7, ext_clk, er;
  int err_count = 0;
  int checks_done = 0;

  cgc_clock_gen_config uut (
    .i_core_clk(i_core_clk), .i_srst(i_srst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_ext_osc_enable(o_ext_osc_enable),
    .o_ext_osc_high_gain(o_ext_osc_high_gain),
    .o_ext_osc_range(o_ext_osc_range), .o_irg_enable(o_irg_enable),
    .o_dco_enable(o_dco_enable), .o_dco_loop_closed(o_dco_loop_closed),
    .o_dco_filter(o_dco_filter), .o_osc_trim(o_osc_trim),
    .o_mode_actual(o_mode_actual), .o_out_external(o_out_external),
    .o_ref_div7(o_ref_div7), .o_prescale(o_prescale),
    .o_mult_n(o_mult_n), .o_div_r(o_div_r)
  );
  cgc_ext_osc_model osc (
    .i_enable(o_ext_osc_enable), .i_high_gain(o_ext_osc_high_gain),
    .i_range(o_ext_osc_range), .o_ref_clk(ext_clk)
  );

  // Core clock, 8 ns period.
  initial begin
    forever #4 i_core_clk = ~i_core_clk;
  end

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // Compares one value; a mismatch is reported at once.
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  // Expected factors worked out from the codes.
  function automatic logic [31:0] exp_n(input logic [2:0] c);
    return 32'h4 + {28'h0, c, 1'b0};
  endfunction : exp_n
  function automatic logic [31:0] exp_r(input logic [2:0] c);
    return 32'h1 << c;
  endfunction : exp_r

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_core_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    chk("pready", 1, o_pready);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string s, input logic [11:0] a,
                       input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(s, e, rd);
  endtask : rdchk

  // Derived outputs trail the registers by one cycle.
  task automatic lag();
    repeat (2) @(posedge i_core_clk);
  endtask : lag

  // Waits for a mode under a bound, then checks it came no sooner.
  task automatic wait_mode(input logic [1:0] m, input int lo,
                           input int hi);
    int n;
    n = 0;
    while (o_mode_actual !== m && n < hi) begin
      @(posedge i_core_clk);
      n++;
    end
    chk("mode", 32'(m), 32'(o_mode_actual));
    chk("mode_delay", 1, 32'(n >= lo));
    lag();
  endtask : wait_mode

  initial begin
    logic [11:0] ra [6];
    logic [31:0] rv [6];
    ra = '{ADDR_CTRL1, ADDR_CTRL2, ADDR_STAT1, ADDR_FLTU, ADDR_FLTL,
           ADDR_TRIM};
    rv = '{32'(CTRL1_RST), 32'(CTRL2_RST), 32'h0, 32'h0, 32'h0,
           32'(TRIM_RST)};
    b = $urandom(33);
    repeat (4) @(posedge i_core_clk);
    i_srst <= 1'b0;
    for (int i = 0; i < 6; i++) rdchk("reset", ra[i], rv[i]);
    // Reserved bits, gain without an oscillator, refused accesses.
    apb(1'b1, ADDR_CTRL1, 32'h81);
    lag();
    chk("gain", 0, o_ext_osc_high_gain);
    rdchk("ctrl1", ADDR_CTRL1, 32'h80);
    apb(1'b1, ADDR_FLTU, 32'hffffffff);
    rdchk("fltu", ADDR_FLTU, 32'hf);
    b = $urandom;
    apb(1'b1, ADDR_FLTL, b);
    rdchk("fltl", ADDR_FLTL, {24'h0, b[7:0]});
    chk("filter", {20'h0, 4'hf, b[7:0]}, 32'(o_dco_filter));
    apb(1'b1, ADDR_TRIM, ~b);
    rdchk("trim", ADDR_TRIM, {24'h0, ~b[7:0]});
    chk("trim_out", {24'h0, ~b[7:0]}, 32'(o_osc_trim));
    apb(1'b1, ADDR_STAT1, 32'hff);
    chk("stat_err", 0, 32'(er));
    rdchk("stat1", ADDR_STAT1, 32'h0);
    apb(1'b1, 12'h01c, 32'hff);
    chk("err_wr", 1, 32'(er));
    rdchk("unmapped", 12'h01c, 32'h0);
    chk("err_rd", 1, 32'(er));
    // Every multiply and divide code, random neighbouring bits.
    for (int i = 0; i < 8; i++) begin
      b = $urandom;
      v = {24'h0, b[7], 3'(i), b[3], 3'(7 - i)};
      apb(1'b1, ADDR_CTRL2, v);
      rdchk("ctrl2", ADDR_CTRL2, v);
      chk("mult_n", exp_n(3'(i)), 32'(o_mult_n));
      chk("div_r", exp_r(3'(7 - i)), 32'(o_div_r));
    end
    // Internal loop, then self-clocked.
    apb(1'b1, ADDR_CTRL1, 32'h28);
    wait_mode(2'b01, 0, 60);
    chk("irg", 1, o_irg_enable);
    chk("dco", 1, o_dco_enable);
    chk("pre", 32'h40, 32'(o_prescale));
    rdchk("stat2", ADDR_STAT2, 32'h1);
    apb(1'b1, ADDR_CTRL1, 32'h00);
    wait_mode(2'b00, 0, 60);
    chk("irg", 0, o_irg_enable);
    chk("dco", 1, o_dco_enable);
    chk("ext", 0, o_out_external);
    // Bypass only after the start-up span.
    apb(1'b1, ADDR_CTRL1, 32'h30);
    wait_mode(2'b10, 120, 300);
    chk("dco", 0, o_dco_enable);
    chk("irg", 0, o_irg_enable);
    chk("osc_en", 1, o_ext_osc_enable);
    // Gain change through self-clocked mode, reselected in one write.
    apb(1'b1, ADDR_CTRL1, 32'h00);
    wait_mode(2'b00, 20, 100);
    chk("osc_off", 0, o_ext_osc_enable);
    chk("ref_idle", 0, ext_clk);
    apb(1'b1, ADDR_CTRL1, 32'hb0);
    lag();
    chk("gain", 1, o_ext_osc_high_gain);
    wait_mode(2'b10, 115, 300);
    // External loop in both ranges.
    apb(1'b1, ADDR_CTRL1, 32'hf8);
    wait_mode(2'b11, 20, 300);
    chk("pre", 32'h1, 32'(o_prescale));
    chk("gain", 1, o_ext_osc_high_gain);
    chk("range", 1, o_ext_osc_range);
    rdchk("stat1", ADDR_STAT1, 32'hea);
    apb(1'b1, ADDR_CTRL1, 32'hb8);
    lag();
    chk("pre", 32'h40, 32'(o_prescale));
    complete_run();
  end

  // Cuts a hang short; the run needs about five hundred cycles.
  initial begin
    #80000;
    err_count++;
    complete_run();
  end
endmodule : cgc_clock_gen_config_test

`default_nettype wire
